// ### core/pio_pkg.sv
// constants, register map and mode codes for the programmable port block
package pio_pkg;
	localparam int NUM_PORTS  = 11;
	localparam int PORT_W     = 8;
	localparam int PIN_W      = NUM_PORTS * PORT_W;
	localparam int GRP_W      = 4;
	localparam int NUM_GRPS   = PIN_W / GRP_W;
	localparam int INPUT_ONLY = 69;
	localparam int SEL_PORT   = 1;
	localparam int ADDR_W     = 12;
	localparam int DATA_W     = 32;

	localparam logic [ADDR_W-1:0] DIR_BASE  = 12'h000;
	localparam logic [ADDR_W-1:0] DATA_BASE = 12'h040;
	localparam logic [ADDR_W-1:0] PU_BASE   = 12'h080;
	localparam logic [ADDR_W-1:0] CTL_OFS   = 12'h08c;
	localparam int NUM_PU_REGS = 3;
	localparam int PU_REG_W    = 8;
	localparam int CTL_SEL_BIT = 0;

	localparam logic [NUM_GRPS-1:0] BUS_GRP_MASK = 22'h00_0dff;
	localparam logic [NUM_GRPS-1:0] PU_RESET     = 22'h00_0000;
	localparam logic [PIN_W-1:0]    DIR_RESET    = {PIN_W{1'b0}};
	localparam logic [PIN_W-1:0]    LATCH_RESET  = {PIN_W{1'b0}};

	typedef enum logic [1:0] {
		PIO_MODE_SINGLE = 2'h0,
		PIO_MODE_MEMEXP = 2'h1,
		PIO_MODE_MICRO  = 2'h2
	} pio_mode_t;
endpackage : pio_pkg

// ### core/pio_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module pio_sync #(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
		end
		else
		begin
			s1_reg <= d;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// a bit changes once stages two and three agree
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			q <= '0;
		else
			q <= (s2_reg & s3_reg) | (q & (s2_reg | s3_reg));
	end
endmodule : pio_sync

// ### core/pio_top.sv
// programmable port block: apb registers, pin drive, pull-ups, readback
`timescale 1ns/1ns
module pio_top
	import pio_pkg::*;
#(
	parameter int DA0_PIN = 75,
	parameter int DA1_PIN = 76
) (
	input  wire logic                           clk,
	input  wire logic                           rst_b,
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [pio_pkg::ADDR_W-1:0]     paddr,
	input  wire logic [pio_pkg::DATA_W-1:0]     pwdata,
	output logic      [pio_pkg::DATA_W-1:0]     prdata,
	output logic                                pready,
	output logic                                pslverr,
	input  wire pio_pkg::pio_mode_t             proc_mode,
	input  wire logic                           bus_8bit,
	input  wire logic                           bus_mux_full,
	input  wire logic [pio_pkg::PIN_W-1:0]      ext_bus_pins,
	input  wire logic [pio_pkg::PIN_W-1:0]      periph_oe,
	input  wire logic [pio_pkg::PIN_W-1:0]      periph_out,
	input  wire logic [1:0]                     da_out_en,
	input  wire logic [pio_pkg::PIN_W-1:0]      pin_in,
	output logic      [pio_pkg::PIN_W-1:0]      pin_out,
	output logic      [pio_pkg::PIN_W-1:0]      pin_oe,
	output logic      [pio_pkg::PIN_W-1:0]      pull_up_en,
	output logic      [pio_pkg::PIN_W-1:0]      pin_level
);
	import pio_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// declarations

	localparam logic [PIN_W-1:0] ONE_PIN = {{(PIN_W-1){1'b0}}, 1'b1};
	localparam logic [PIN_W-1:0] IN_ONLY_MASK = ONE_PIN << INPUT_ONLY;
	localparam logic [PIN_W-1:0] DA_MASK0 = ONE_PIN << DA0_PIN;
	localparam logic [PIN_W-1:0] DA_MASK1 = ONE_PIN << DA1_PIN;

	// address fields: word index above the byte offset, block select above the index
	localparam int                 IDX_LSB      = 2;
	localparam int                 PORT_BLK_LSB = 6;
	localparam int                 PU_BLK_LSB   = 4;
	localparam logic [IDX_LSB-1:0] WORD_ALIGNED = '0;

	logic [PIN_W-1:0]    dir_reg;
	logic [PIN_W-1:0]    latch_reg;
	logic [NUM_GRPS-1:0] pu_reg;
	logic                sel_ctl_reg;
	logic [PIN_W-1:0]    pin_sync;
	logic [PIN_W-1:0]    rd_vec;
	logic [PIN_W-1:0]    protect;
	logic [PIN_W-1:0]    pu_grp_pins;
	logic [PIN_W-1:0]    da_pins;
	logic [PIN_W-1:0]    pu_next;
	logic [PIN_W-1:0]    pin_out_next;
	logic [PIN_W-1:0]    pin_oe_next;
	logic                bus_mode;
	logic                sel_latch;
	logic                wr_en;
	logic                setup;
	logic [3:0]          port_idx;
	logic                is_dir;
	logic                is_data;
	logic                is_pu;
	logic                is_ctl;
	logic                hit;
	logic [1:0]          pu_idx;
	logic [DATA_W-1:0]   rd_next;

	// expand one byte into an 88-bit vector placed at a port
	function automatic logic [PIN_W-1:0] place_port(
		input logic [PORT_W-1:0] v,
		input logic [3:0]        idx
	);
		logic [PIN_W-1:0] r;
		r = {{(PIN_W-PORT_W){1'b0}}, v};
		return r << (int'(idx) * PORT_W);
	endfunction : place_port

	// pick the byte of one port out of an 88-bit vector
	function automatic logic [PORT_W-1:0] port_byte(
		input logic [PIN_W-1:0] v,
		input logic [3:0]       idx
	);
		logic [PIN_W-1:0] s;
		s = v >> (int'(idx) * PORT_W);
		return s[PORT_W-1:0];
	endfunction : port_byte

	// pull-up group g sits in the addressed pull-up register
	function automatic logic grp_in_reg(
		input int         g,
		input logic [1:0] idx
	);
		return (g / PU_REG_W) == int'(idx);
	endfunction : grp_in_reg

	////////////////////////////////////////////////////////////////////////
	// input synchroniser

	pio_sync #(
		.W (PIN_W)
	) u_sync (
		.clk   (clk),
		.rst_b (rst_b),
		.d     (pin_in),
		.q     (pin_sync)
	);

	////////////////////////////////////////////////////////////////////////
	// apb decode

	assign setup    = psel && !penable;
	assign wr_en    = psel && penable && pwrite;
	assign port_idx = paddr[PORT_BLK_LSB-1:IDX_LSB];
	assign pu_idx   = paddr[PU_BLK_LSB-1:IDX_LSB];

	always_comb
	begin
		is_dir  = (paddr[ADDR_W-1:PORT_BLK_LSB] == DIR_BASE[ADDR_W-1:PORT_BLK_LSB])
			&& (int'(port_idx) < NUM_PORTS) && (paddr[IDX_LSB-1:0] == WORD_ALIGNED);
		is_data = (paddr[ADDR_W-1:PORT_BLK_LSB] == DATA_BASE[ADDR_W-1:PORT_BLK_LSB])
			&& (int'(port_idx) < NUM_PORTS) && (paddr[IDX_LSB-1:0] == WORD_ALIGNED);
		is_pu   = (paddr[ADDR_W-1:PU_BLK_LSB] == PU_BASE[ADDR_W-1:PU_BLK_LSB])
			&& (int'(pu_idx) < NUM_PU_REGS) && (paddr[IDX_LSB-1:0] == WORD_ALIGNED);
		is_ctl  = (paddr == CTL_OFS);
		hit     = is_dir || is_data || is_pu || is_ctl;
	end

	assign pready = 1'b1;

	////////////////////////////////////////////////////////////////////////
	// mode qualifiers

	assign bus_mode  = (proc_mode == PIO_MODE_MEMEXP) || (proc_mode == PIO_MODE_MICRO);
	assign protect   = bus_mode ? ext_bus_pins : {PIN_W{1'b0}};
	assign sel_latch = sel_ctl_reg && ((bus_mode && bus_8bit) || bus_mux_full);

	////////////////////////////////////////////////////////////////////////
	// direction bits

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			dir_reg <= DIR_RESET;
		else if (wr_en && is_dir)
			dir_reg <= ((dir_reg & (protect | ~place_port({PORT_W{1'b1}}, port_idx)))
				| (place_port(pwdata[PORT_W-1:0], port_idx) & ~protect))
				& ~IN_ONLY_MASK;
	end

	////////////////////////////////////////////////////////////////////////
	// output latches

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			latch_reg <= LATCH_RESET;
		else if (wr_en && is_data)
			latch_reg <= (latch_reg & (protect | ~place_port({PORT_W{1'b1}}, port_idx)))
				| (place_port(pwdata[PORT_W-1:0], port_idx) & ~protect);
	end

	////////////////////////////////////////////////////////////////////////
	// pull-up groups and port control

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			pu_reg <= PU_RESET;
		else if (wr_en && is_pu)
		begin
			for (int i = 0; i < NUM_GRPS; i++)
			begin
				if (grp_in_reg(i, pu_idx))
					pu_reg[i] <= pwdata[i % PU_REG_W];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			sel_ctl_reg <= 1'b0;
		else if (wr_en && is_ctl)
			sel_ctl_reg <= pwdata[CTL_SEL_BIT];
	end

	////////////////////////////////////////////////////////////////////////
	// readback vector

	always_comb
	begin
		rd_vec = (dir_reg & latch_reg) | (~dir_reg & pin_sync);
		if (sel_latch)
			rd_vec[SEL_PORT*PORT_W +: PORT_W] = latch_reg[SEL_PORT*PORT_W +: PORT_W];
		rd_vec[INPUT_ONLY] = pin_sync[INPUT_ONLY];
	end

	always_comb
	begin
		rd_next = '0;
		if (is_dir)
			rd_next[PORT_W-1:0] = port_byte(dir_reg, port_idx);
		else if (is_data)
			rd_next[PORT_W-1:0] = port_byte(rd_vec, port_idx);
		else if (is_pu)
		begin
			for (int i = 0; i < NUM_GRPS; i++)
			begin
				if (grp_in_reg(i, pu_idx))
					rd_next[i % PU_REG_W] = pu_reg[i];
			end
		end
		else if (is_ctl)
			rd_next[CTL_SEL_BIT] = sel_ctl_reg;
	end

	// read data and error are captured in the setup cycle
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			prdata <= '0;
		else if (setup)
			prdata <= pwrite ? '0 : rd_next;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			pslverr <= 1'b0;
		else if (setup)
			pslverr <= !hit;
	end

	////////////////////////////////////////////////////////////////////////
	// pin drive and pull-ups

	always_comb
	begin
		da_pins = ({PIN_W{da_out_en[0]}} & DA_MASK0) | ({PIN_W{da_out_en[1]}} & DA_MASK1);
		for (int g = 0; g < NUM_GRPS; g++)
		begin
			for (int b = 0; b < GRP_W; b++)
				pu_grp_pins[g*GRP_W+b] = pu_reg[g] && !(bus_mode && BUS_GRP_MASK[g]);
		end
		pu_next = pu_grp_pins & ~dir_reg & ~periph_oe
			& ~da_pins
			& ~IN_ONLY_MASK;
		pin_oe_next  = (dir_reg | periph_oe) & ~IN_ONLY_MASK;
		pin_out_next = (periph_oe & periph_out) | (~periph_oe & latch_reg);
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			pin_oe <= '0;
		else
			pin_oe <= pin_oe_next;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			pin_out <= '0;
		else
			pin_out <= pin_out_next;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			pull_up_en <= '0;
		else
			pull_up_en <= pu_next;
	end

	// synchronised pin levels for on-chip peripherals
	assign pin_level = pin_sync;
endmodule : pio_top

// ### sim/pio_ext_dev.sv
// external devices on the pads: drive, float or pull, resolved to the pad level
`timescale 1ns/1ns
module pio_ext_dev
	import pio_pkg::*;
(
	input  wire logic                      clk,
	input  wire logic [pio_pkg::PIN_W-1:0] pin_out,
	input  wire logic [pio_pkg::PIN_W-1:0] pin_oe,
	input  wire logic [pio_pkg::PIN_W-1:0] pull_up_en,
	input  wire logic [pio_pkg::PIN_W-1:0] ext_drv,
	input  wire logic [pio_pkg::PIN_W-1:0] ext_val,
	output logic      [pio_pkg::PIN_W-1:0] pin_in
);
	logic [PIN_W-1:0] flt_reg = '0;
	// undriven pads without a pull-up wander every cycle
	always_ff @(posedge clk)
	begin
		flt_reg <= ~flt_reg;
	end
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drv & ext_val)
		| (~pin_oe & ~ext_drv & (pull_up_en | flt_reg));
endmodule : pio_ext_dev

// ### sim/pio_top_monitor.sv
// concurrent checks on pin drive, pull-ups and apb answers
`timescale 1ns/1ns
module pio_top_monitor
	import pio_pkg::*;
#(
	parameter int DA0_PIN = 75
) (
	input  wire logic                      clk,
	input  wire logic                      rst_b,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic [pio_pkg::ADDR_W-1:0] paddr,
	input  wire logic                      pready,
	input  wire logic                      pslverr,
	input  wire pio_pkg::pio_mode_t        proc_mode,
	input  wire logic [pio_pkg::PIN_W-1:0] periph_oe,
	input  wire logic [pio_pkg::PIN_W-1:0] periph_out,
	input  wire logic [1:0]                da_out_en,
	input  wire logic [pio_pkg::PIN_W-1:0] pin_out,
	input  wire logic [pio_pkg::PIN_W-1:0] pin_oe,
	input  wire logic [pio_pkg::PIN_W-1:0] pull_up_en
);
	logic [PIN_W-1:0] pm;
	logic [PIN_W-1:0] bm;
	assign pm = periph_oe & ~(PIN_W'(1) << INPUT_ONLY);
	for (genvar g = 0; g < NUM_GRPS; g++)
	begin : g_bm
		assign bm[g*GRP_W +: GRP_W] = {GRP_W{BUS_GRP_MASK[g]}};
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	////////////////////////////////////////////////////////////////////////////////
	chk_only_in_idle: assert property (!pin_oe[INPUT_ONLY] && !pull_up_en[INPUT_ONLY])
		else $error("input-only pin driven or pulled");
	chk_pull_not_out: assert property ((pin_oe & pull_up_en) == '0)
		else $error("pull-up on a driven pin");
	chk_periph_oe: assert property ($past(rst_b) |-> (pin_oe & $past(pm)) == $past(pm))
		else $error("peripheral output not driven");
	chk_periph_val: assert property (
		$past(rst_b) |-> ((pin_out ^ $past(periph_out)) & $past(pm)) == '0)
		else $error("peripheral output value wrong");
	chk_da_no_pull: assert property (
		$past(rst_b) && $past(da_out_en[0]) |-> !pull_up_en[DA0_PIN])
		else $error("pull-up left on converter pin");
	chk_bus_no_pull: assert property (
		$past(rst_b) && $past(proc_mode) != PIO_MODE_SINGLE |-> (pull_up_en & bm) == '0)
		else $error("pull-up on bus group in bus mode");
	chk_reset_idle: assert property ($rose(rst_b) |-> pin_oe == '0 && pull_up_en == '0)
		else $error("pins not idle after reset");
	chk_zero_wait: assert property (psel && penable |-> pready)
		else $error("access phase without ready");
	chk_unmapped_err: assert property (psel && penable && paddr >= 12'h090 |-> pslverr)
		else $error("unmapped access without error");
endmodule : pio_top_monitor

bind pio_top pio_top_monitor #(.DA0_PIN(DA0_PIN)) u_mon (.clk(clk), .rst_b(rst_b), .psel(psel),
	.penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .proc_mode(proc_mode),
	.periph_oe(periph_oe), .periph_out(periph_out), .da_out_en(da_out_en), .pin_out(pin_out),
	.pin_oe(pin_oe), .pull_up_en(pull_up_en));

// ### sim/pio_top_tb.sv
// self-checking bench for the port block
`timescale 1ns/1ns
module pio_top_tb;
	import pio_pkg::*;
	logic              clk = 0;
	logic              rst_b = 0;
	logic              psel = 0;
	logic              penable = 0;
	logic              pwrite = 0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [DATA_W-1:0] pwdata = '0;
	logic [DATA_W-1:0] prdata;
	logic              pready;
	logic              pslverr;
	pio_mode_t         proc_mode = PIO_MODE_SINGLE;
	logic              bus_8bit = 0;
	logic              bus_mux_full = 0;
	logic [PIN_W-1:0]  ext_bus_pins = '0;
	logic [PIN_W-1:0]  periph_oe = '0;
	logic [PIN_W-1:0]  periph_out = '0;
	logic [1:0]        da_out_en = '0;
	logic [PIN_W-1:0]  pin_in, pin_out, pin_oe, pull_up_en, pin_level;
	logic [PIN_W-1:0]  ext_drv = '0;
	logic [PIN_W-1:0]  ext_val = '0;
	logic [31:0]       rd;
	logic              er;
	int                n_errors = 0;
	int                n_tests = 0;
	int                cyc = 0;
	pio_top u_dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.proc_mode(proc_mode), .bus_8bit(bus_8bit), .bus_mux_full(bus_mux_full),
		.ext_bus_pins(ext_bus_pins), .periph_oe(periph_oe), .periph_out(periph_out),
		.da_out_en(da_out_en), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.pull_up_en(pull_up_en), .pin_level(pin_level));
	pio_ext_dev u_ext (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en),
		.ext_drv(ext_drv), .ext_val(ext_val), .pin_in(pin_in));
	always #2 clk = ~clk;
	////////////////////////////////////////////////////////////////////////////////
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_errors++;
			conclude();
		end
	end
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1, a, {24'h00_0000, d});
	endtask : wr
	task automatic rdc(input string n, input logic [11:0] a, input logic [7:0] e);
		apb(0, a, 32'h0000_0000);
		chk(n, rd, {24'h00_0000, e});
	endtask : rdc
	task automatic w8(input int n);
		repeat (n) @(posedge clk);
	endtask : w8
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rdc("dir0", DIR_BASE, 8'h00);
		rdc("pu0", PU_BASE, 8'h00);
		rdc("pu2", PU_BASE + 12'h008, 8'h00);
		chk("oe", pin_oe[31:0], 32'h0000_0000);
		chk("pull", pull_up_en[31:0], 32'h0000_0000);
	endtask : t_reset
	task automatic t_out;
		wr(DIR_BASE + 12'h008, 8'hff);
		wr(DATA_BASE + 12'h008, 8'ha5);
		w8(2);
		chk("oe2", pin_oe[23:16], 8'hff);
		chk("out2", pin_out[23:16], 8'ha5);
		rdc("dat2", DATA_BASE + 12'h008, 8'ha5);
	endtask : t_out
	task automatic t_pull;
		ext_drv[31:28] <= 4'hf;
		ext_val[31:28] <= 4'h3;
		wr(PU_BASE, 8'h40);
		w8(8);
		chk("pu3", pull_up_en[31:24], 8'h0f);
		chk("lvl3", pin_level[31:28], 4'h3);
		rdc("dat3", DATA_BASE + 12'h00c, 8'h3f);
		wr(DIR_BASE + 12'h00c, 8'h01);
		w8(2);
		chk("pu3o", pull_up_en[31:24], 8'h0e);
		wr(PU_BASE + 12'h008, 8'h3f);
		rdc("pu2", PU_BASE + 12'h008, 8'h3f);
		w8(2);
		chk("pu8", pull_up_en[71:64], 8'hdf);
		chk("da", pull_up_en[76:75], 2'h3);
		da_out_en <= 2'h1;
		w8(2);
		chk("da0", pull_up_en[76:75], 2'h2);
		da_out_en <= 2'h2;
		w8(2);
		chk("da1", pull_up_en[76:75], 2'h1);
		da_out_en <= 2'h0;
	endtask : t_pull
	task automatic t_periph;
		periph_oe[39] <= 1;
		periph_out[39] <= 1;
		w8(2);
		chk("po", {pin_oe[39], pin_out[39]}, 2'b11);
		periph_oe[39] <= 0;
	endtask : t_periph
	task automatic t_bus;
		ext_drv[7:4] <= 4'hf;
		wr(DIR_BASE, 8'h0f);
		wr(DATA_BASE, 8'h05);
		proc_mode <= PIO_MODE_MEMEXP;
		ext_bus_pins[7:0] <= 8'hff;
		wr(DIR_BASE, 8'hff);
		wr(DATA_BASE, 8'hfa);
		wr(PU_BASE, 8'h41);
		w8(6);
		rdc("bdir", DIR_BASE, 8'h0f);
		rdc("bdat", DATA_BASE, 8'h05);
		rdc("bpu", PU_BASE, 8'h41);
		chk("bpu3", pull_up_en[31:24], 8'h00);
		proc_mode <= PIO_MODE_SINGLE;
		ext_bus_pins <= '0;
	endtask : t_bus
	task automatic t_rsel;
		ext_drv[15:8] <= 8'hfc;
		ext_val[15:8] <= 8'hf0;
		wr(DIR_BASE + 12'h004, 8'h03);
		wr(DATA_BASE + 12'h004, 8'h0f);
		wr(CTL_OFS, 8'h01);
		rdc("ctl", CTL_OFS, 8'h01);
		w8(8);
		rdc("p1s", DATA_BASE + 12'h004, 8'hf3);
		proc_mode <= PIO_MODE_MICRO;
		bus_8bit <= 1;
		rdc("p1b", DATA_BASE + 12'h004, 8'h0f);
		bus_8bit <= 0;
		bus_mux_full <= 1;
		rdc("p1m", DATA_BASE + 12'h004, 8'h0f);
		bus_mux_full <= 0;
		rdc("p1n", DATA_BASE + 12'h004, 8'hf3);
		bus_8bit <= 1;
		wr(CTL_OFS, 8'h00);
		rdc("p1z", DATA_BASE + 12'h004, 8'hf3);
		proc_mode <= PIO_MODE_SINGLE;
	endtask : t_rsel
	task automatic t_unmap;
		apb(0, 12'hffc, 32'h0000_0000);
		chk("err", er, 1'b1);
		chk("rd", rd, 32'h0000_0000);
	endtask : t_unmap
	initial
	begin
		repeat (16) @(posedge clk);
		rst_b <= 1;
		t_reset();
		t_out();
		t_pull();
		t_periph();
		t_bus();
		t_rsel();
		t_unmap();
		conclude();
	end
endmodule : pio_top_tb
